// ===== hdl/pixel_chain_pkg.sv
package pixel_chain_pkg;
    // datapath widths
    localparam int PIX_W     = 12;
    localparam int AGAIN_W   = 6;
    localparam int DGAIN_W   = 7;
    localparam int DOFF_W    = 12;
    localparam int AOFF_W    = 9;
    localparam int EO_W      = 8;
    localparam int GAIN_FRAC = 3;
    localparam int COLORS    = 4;
    // color codes carried with each sample
    localparam logic [1:0] COLOR_GREEN_A = 2'h0;
    localparam logic [1:0] COLOR_RED     = 2'h1;
    localparam logic [1:0] COLOR_BLUE    = 2'h2;
    localparam logic [1:0] COLOR_GREEN_B = 2'h3;
    // one analog offset code moves the converter input by this many LSBs
    localparam logic signed [19:0] AOFF_STEP_LSB = 20'sh00004;
    // calibration step sizes and code limits, in offset codes
    localparam int AOFF_COARSE = 16;
    localparam int AOFF_FINE   = 1;
    localparam int AOFF_MAX    = 255;
    localparam int AOFF_MIN    = -256;
    // averaging windows, as log2 of sample counts
    localparam int BLC_LOG2  = 4;
    localparam int ROW_BLACK_LEVEL_CALIBRATION_LOG2 = 3;
    localparam int EO_LOG2   = 5;
    // reset value and pixel maximum
    localparam logic [AOFF_W-1:0] AOFF_RESET = 9'h000;
    localparam logic [PIX_W-1:0]  PIX_MAX    = 12'hfff;
    // output buffer
    localparam int FIFO_DEPTH = 32;
endpackage : pixel_chain_pkg

// ===== hdl/pixel_fifo.sv
// output buffer: flip-flop storage, indexed by read and write pointers
module pixel_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_t;

    fifo_t q;
    fifo_t d;
    logic  push;
    logic  pop;

    // full and empty come straight from the occupancy count
    assign in_ready  = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers wrap at DEPTH, which need not be a power of two
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp        = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : pixel_fifo

// ===== hdl/pixel_gain_offset_chain.sv
// per-color gain and offset chain with black level calibration
module pixel_gain_offset_chain
    import pixel_chain_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // incoming samples
    input  wire logic                              pix_in_valid,
    output logic                                   pix_in_ready,
    input  wire logic [PIX_W-1:0]                  pix_in_sample,
    input  wire logic [1:0]                        pix_in_color,
    input  wire logic                              pix_in_odd,
    input  wire logic                              pix_in_dark_row,
    input  wire logic                              pix_in_dark_col,
    input  wire logic                              row_start,
    input  wire logic                              frame_end,
    // gain settings, indexed by color code
    input  wire logic [COLORS-1:0][AGAIN_W-1:0]    analog_gain_field,
    input  wire logic [COLORS-1:0]                 gain_doubler,
    input  wire logic [COLORS-1:0][DGAIN_W-1:0]    digital_gain_field,
    // analog calibration control
    input  wire logic                              manual_calibration_select,
    input  wire logic                              green_lock,
    input  wire logic [COLORS-1:0][AOFF_W-1:0]     manual_analog_offset,
    input  wire logic [PIX_W-1:0]                  blc_target_lo,
    input  wire logic [PIX_W-1:0]                  blc_target_hi,
    // digital offset control
    input  wire logic                              row_black_level_calibration,
    input  wire logic [PIX_W-1:0]                  row_black_level_calibration_target,
    input  wire logic [COLORS-1:0][DOFF_W-1:0]     user_digital_offset,
    input  wire logic [COLORS-1:0][EO_W-1:0]       manual_even_odd_offset,
    // status
    output logic [COLORS-1:0][AOFF_W-1:0]          analog_offset_now,
    output logic [COLORS-1:0]                      calib_coarse,
    // processed pixel output
    output logic                                   dout_valid,
    input  wire logic                              dout_ready,
    output logic [PIX_W-1:0]                       dout
);
    // state of the block, apart from the output buffer
    typedef struct packed {
        logic                                s1_v;
        logic [1:0]                          s1_c;
        logic                                s1_odd;
        logic                                s1_dr;
        logic                                s1_dc;
        logic [PIX_W-1:0]                    s1_x;
        logic                                s2_v;
        logic [PIX_W-1:0]                    s2_x;
        logic [COLORS-1:0][AOFF_W-1:0]       aoff;
        logic [COLORS-1:0]                   coarse;
        logic [COLORS-1:0][AGAIN_W:0]        gprev;
        logic [COLORS-1:0][15:0]             bsum;
        logic [COLORS-1:0][BLC_LOG2:0]       bcnt;
        logic [COLORS-1:0][14:0]             rsum;
        logic [COLORS-1:0][ROW_BLACK_LEVEL_CALIBRATION_LOG2:0]      rcnt;
        logic [COLORS-1:0][17:0]             esum;
        logic [COLORS-1:0][EO_LOG2:0]        ecnt;
        logic [COLORS-1:0][EO_W-1:0]         eo;
    } state_t;

    localparam state_t ST_RESET = '{coarse: {COLORS{1'b1}}, aoff: {COLORS{AOFF_RESET}}, default: '0};

    state_t                        s_q;
    state_t                        s_d;
    logic                          en;
    logic                          fifo_in_ready;
    logic [COLORS-1:0][AOFF_W-1:0] aoff_eff;
    logic                          green_same;

    // saturate a signed sum to the unsigned pixel range
    function automatic logic [PIX_W-1:0] clamp12(input logic signed [19:0] v);
        if (v < 20'sh00000) begin
            return '0;
        end else if (v > 20'sh00fff) begin
            return PIX_MAX;
        end
        return v[PIX_W-1:0];
    endfunction : clamp12

    // analog gain, then analog offset, then the 12-bit conversion
    function automatic logic [PIX_W-1:0] analog_conv(
        input logic [PIX_W-1:0]   x,
        input logic [AGAIN_W-1:0] g,
        input logic               m,
        input logic [AOFF_W-1:0]  off
    );
        logic [18:0]        prod;
        logic signed [19:0] sum;
        prod = 19'(x) * 19'(g);
        if (m) begin
            prod = prod << 1;
        end
        sum = $signed({4'h0, prod[18:GAIN_FRAC]}) + $signed({{11{off[AOFF_W-1]}}, off}) * AOFF_STEP_LSB;
        return clamp12(sum);
    endfunction : analog_conv

    // next offset code, held inside the signed code range
    function automatic logic [AOFF_W-1:0] step_off(input logic [AOFF_W-1:0] cur, input int delta);
        int v;
        v = int'($signed(cur)) + delta;
        if (v > AOFF_MAX) begin
            v = AOFF_MAX;
        end else if (v < AOFF_MIN) begin
            v = AOFF_MIN;
        end
        return v[AOFF_W-1:0];
    endfunction : step_off

    // the whole pipeline stalls while the buffer refuses a word
    assign en = !s_q.s2_v || fifo_in_ready;
    assign pix_in_ready = en;

    // green channels share one analog offset when locked and their gains match
    assign green_same = (analog_gain_field[COLOR_GREEN_A] == analog_gain_field[COLOR_GREEN_B])
                     && (gain_doubler[COLOR_GREEN_A] == gain_doubler[COLOR_GREEN_B]);

    // offsets actually applied: manual values override the loop
    always_comb begin
        for (int i = 0; i < COLORS; i++) begin
            aoff_eff[i] = manual_calibration_select ? manual_analog_offset[i] : s_q.aoff[i];
        end
        if (green_lock && green_same) begin
            aoff_eff[COLOR_GREEN_B] = aoff_eff[COLOR_GREEN_A];
        end
    end

    // status readback
    assign analog_offset_now = aoff_eff;
    assign calib_coarse      = s_q.coarse;

    // next state
    always_comb begin
        logic [1:0]         c1;
        logic [19:0]        dprod;
        logic signed [12:0] doff;
        logic signed [19:0] dsum;
        logic [AGAIN_W:0]   gnow;
        logic [PIX_W-1:0]   avg;
        logic [PIX_W-1:0]   ravg;
        int                 stp;
        s_d   = s_q;
        c1    = s_q.s1_c;
        dprod = '0;
        doff  = '0;
        dsum  = '0;
        gnow  = '0;
        avg   = '0;
        ravg  = '0;
        stp   = 0;

        // stage one: analog chain, each color with its own settings
        if (en) begin
            s_d.s1_v = pix_in_valid;
            if (pix_in_valid) begin
                s_d.s1_c   = pix_in_color;
                s_d.s1_odd = pix_in_odd;
                s_d.s1_dr  = pix_in_dark_row;
                s_d.s1_dc  = pix_in_dark_col;
                s_d.s1_x   = analog_conv(pix_in_sample,
                                         analog_gain_field[pix_in_color],
                                         gain_doubler[pix_in_color],
                                         aoff_eff[pix_in_color]);
            end
        end

        // stage two: digital gain, then the digital offsets
        if (en) begin
            s_d.s2_v = s_q.s1_v;
            if (s_q.s1_v) begin
                dprod = 20'(s_q.s1_x) * (20'(digital_gain_field[c1]) + 20'h00008);
                ravg  = 12'(s_q.rsum[c1] >> ROW_BLACK_LEVEL_CALIBRATION_LOG2);
                if (!row_black_level_calibration) begin
                    doff = $signed({user_digital_offset[c1][DOFF_W-1], user_digital_offset[c1]});
                end else if (s_q.rcnt[c1][ROW_BLACK_LEVEL_CALIBRATION_LOG2]) begin
                    doff = $signed({1'b0, row_black_level_calibration_target}) - $signed({1'b0, ravg});
                end
                dsum = $signed({3'h0, dprod[19:GAIN_FRAC]}) + 20'(doff);
                if (s_q.s1_odd) begin
                    if (manual_calibration_select) begin
                        dsum = dsum + 20'($signed(manual_even_odd_offset[c1]));
                    end else begin
                        dsum = dsum + 20'($signed(s_q.eo[c1]));
                    end
                end
                s_d.s2_x = clamp12(dsum);
            end
        end

        // sampling of dark rows; none in manual mode
        if (en && s_q.s1_v && !manual_calibration_select) begin
            if (s_q.s1_dr && !s_q.bcnt[c1][BLC_LOG2]) begin
                s_d.bsum[c1] = s_q.bsum[c1] + 16'(s_q.s1_x);
                s_d.bcnt[c1] = s_q.bcnt[c1] + 1'b1;
            end
            // even pixels add, odd ones subtract: the sum is the even/odd skew
            if (s_q.s1_dr && !s_q.ecnt[c1][EO_LOG2]) begin
                if (s_q.s1_odd) begin
                    s_d.esum[c1] = s_q.esum[c1] - 18'(s_q.s1_x);
                end else begin
                    s_d.esum[c1] = s_q.esum[c1] + 18'(s_q.s1_x);
                end
                s_d.ecnt[c1] = s_q.ecnt[c1] + 1'b1;
            end
        end

        // row averages come from dark columns, even in manual mode
        if (en && s_q.s1_v && s_q.s1_dc && !s_q.rcnt[c1][ROW_BLACK_LEVEL_CALIBRATION_LOG2]) begin
            s_d.rsum[c1] = s_q.rsum[c1] + 15'(s_q.s1_x);
            s_d.rcnt[c1] = s_q.rcnt[c1] + 1'b1;
        end
        if (row_start) begin
            s_d.rsum = '0;
            s_d.rcnt = '0;
        end

        // a gain change calls for a large correction next time
        for (int i = 0; i < COLORS; i++) begin
            gnow = {gain_doubler[i], analog_gain_field[i]};
            if (gnow != s_q.gprev[i]) begin
                s_d.gprev[i]  = gnow;
                s_d.coarse[i] = 1'b1;
            end
        end

        // end of frame: compare each full dark average with the window
        if (frame_end) begin
            for (int i = 0; i < COLORS; i++) begin
                avg = 12'(s_q.bsum[i] >> BLC_LOG2);
                stp = s_q.coarse[i] ? AOFF_COARSE : AOFF_FINE;
                if (!manual_calibration_select && s_q.bcnt[i][BLC_LOG2]) begin
                    if (avg < blc_target_lo) begin
                        s_d.aoff[i] = step_off(s_q.aoff[i], stp);
                    end else if (avg > blc_target_hi) begin
                        s_d.aoff[i] = step_off(s_q.aoff[i], -stp);
                    end else if (s_d.gprev[i] == s_q.gprev[i]) begin
                        s_d.coarse[i] = 1'b0;
                    end
                end
                // odd pixels get the mean skew per pair, cut to its low 8 bits
                if (!manual_calibration_select && s_q.ecnt[i][EO_LOG2]) begin
                    s_d.eo[i] = EO_W'($signed(s_q.esum[i]) >>> (EO_LOG2 - 1));
                end
            end
            s_d.bsum = '0;
            s_d.bcnt = '0;
            s_d.esum = '0;
            s_d.ecnt = '0;
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // the buffer absorbs output stalls without losing pixels
    pixel_fifo #(
        .WIDTH (PIX_W),
        .DEPTH (FIFO_WORDS)
    ) u_out_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (s_q.s2_v && en),
        .in_ready  (fifo_in_ready),
        .in_data   (s_q.s2_x),
        .out_valid (dout_valid),
        .out_ready (dout_ready),
        .out_data  (dout)
    );
endmodule : pixel_gain_offset_chain

// ===== bench/pixel_gain_offset_chain_monitor.sv
// port-level checks of the pixel chain, bound into the top module
module pixel_gain_offset_chain_monitor
    import pixel_chain_pkg::*;
(
    // clock and reset
    input wire logic                           clk_sys,
    input wire logic                           rst,
    // stream and control
    input wire logic                           pix_in_valid,
    input wire logic                           pix_in_ready,
    input wire logic                           frame_end,
    input wire logic [COLORS-1:0][AGAIN_W-1:0] analog_gain_field,
    input wire logic [COLORS-1:0]              gain_doubler,
    input wire logic                           manual_calibration_select,
    input wire logic                           green_lock,
    input wire logic [COLORS-1:0][AOFF_W-1:0]  manual_analog_offset,
    // status and output
    input wire logic [COLORS-1:0][AOFF_W-1:0]  analog_offset_now,
    input wire logic [COLORS-1:0]              calib_coarse,
    input wire logic                           dout_valid,
    input wire logic                           dout_ready,
    input wire logic [PIX_W-1:0]               dout
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a take into an empty pipe with nothing in flight
    sequence s_fresh_take;
        !dout_valid && pix_in_valid && pix_in_ready && !$past(pix_in_valid && pix_in_ready)
            && !$past(pix_in_valid && pix_in_ready, 2);
    endsequence
    sequence s_pipe_fill;
        !dout_valid [*2] ##1 dout_valid;
    endsequence
    property p_latency; s_fresh_take |=> s_pipe_fill; endproperty
    a_latency: assert property (p_latency) else $error("output word late or early");
    property p_stand; dout_valid && !dout_ready |=> dout_valid && $stable(dout); endproperty
    a_stand: assert property (p_stand) else $error("output word dropped while stalled");
    property p_refuse; !pix_in_ready |-> dout_valid; endproperty
    a_refuse: assert property (p_refuse) else $error("input refused with empty buffer");
    property p_reset_vals;
        $past(rst) |-> calib_coarse == 4'hf && (manual_calibration_select || analog_offset_now[1] == AOFF_RESET);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad calibration state after reset");
    // coarse mode may only end when a frame closes
    property p_coarse_clear; |($past(calib_coarse) & ~calib_coarse) |-> $past(frame_end); endproperty
    a_coarse_clear: assert property (p_coarse_clear) else $error("coarse flag cleared off frame end");
    property p_step;
        !manual_calibration_select && !$past(manual_calibration_select)
            && analog_offset_now[1] != $past(analog_offset_now[1]) |-> $past(frame_end)
            && ($past(calib_coarse[1]) ? (9'(analog_offset_now[1] - $past(analog_offset_now[1])) inside {9'h010, 9'h1f0})
                                       : (9'(analog_offset_now[1] - $past(analog_offset_now[1])) inside {9'h001, 9'h1ff}));
    endproperty
    a_step: assert property (p_step) else $error("analog offset moved by a wrong step");
    property p_manual;
        manual_calibration_select |-> analog_offset_now[1] == manual_analog_offset[1]
            && analog_offset_now[2] == manual_analog_offset[2];
    endproperty
    a_manual: assert property (p_manual) else $error("manual offset not in use");
    property p_lock;
        green_lock && analog_gain_field[0] == analog_gain_field[3] && gain_doubler[0] == gain_doubler[3]
            |-> analog_offset_now[3] == analog_offset_now[0];
    endproperty
    a_lock: assert property (p_lock) else $error("locked greens differ in offset");
endmodule : pixel_gain_offset_chain_monitor

bind pixel_gain_offset_chain pixel_gain_offset_chain_monitor u_monitor (.clk_sys, .rst, .pix_in_valid,
    .pix_in_ready, .frame_end, .analog_gain_field, .gain_doubler, .manual_calibration_select, .green_lock,
    .manual_analog_offset, .analog_offset_now, .calib_coarse, .dout_valid, .dout_ready, .dout);

// ===== bench/pixel_sink_model.sv
// downstream receiver: takes a word on each edge with valid and ready high
module pixel_sink_model
    import pixel_chain_pkg::*;
(
    // clock and reset
    input wire logic             clk_sys,
    input wire logic             rst,
    // stall request from the bench
    input wire logic             stall,
    // pixel stream
    input wire logic             dout_valid,
    output logic                 dout_ready,
    input wire logic [PIX_W-1:0] dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PIX_W-1:0] words[$];
    // ready follows the stall line, which the bench moves off the sampling edge
    assign dout_ready = !stall;
    // capture in arrival order so the bench can check pairing
    always_ff @(posedge clk_sys) begin
        if (!rst && dout_valid && dout_ready) begin
            words.push_back(dout);
        end
    end
endmodule : pixel_sink_model

// ===== bench/pixel_gain_offset_chain_tb.sv
module pixel_gain_offset_chain_tb;
    import pixel_chain_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int c; int x; int g; int m; int dg; int ao; int doff; int eo; int odd;} case_t;
    logic clk_sys = 0, rst = 1, pix_in_valid = 0, pix_in_odd = 0, pix_in_dark_row = 0, pix_in_dark_col = 0;
    logic row_start = 0, frame_end = 0, manual_calibration_select = 1, green_lock = 0, stall = 0;
    logic row_black_level_calibration = 0, pix_in_ready, dout_valid, dout_ready;
    logic [1:0] pix_in_color = 0;
    logic [PIX_W-1:0] pix_in_sample = 0, blc_target_lo = 12'h064, blc_target_hi = 12'h0c8;
    logic [PIX_W-1:0] row_black_level_calibration_target = 12'h032, dout, w;
    logic [COLORS-1:0][AGAIN_W-1:0] analog_gain_field = {4{6'h08}};
    logic [COLORS-1:0] gain_doubler = 4'h0, calib_coarse;
    logic [COLORS-1:0][DGAIN_W-1:0] digital_gain_field = '0;
    logic [COLORS-1:0][AOFF_W-1:0] manual_analog_offset = '0, analog_offset_now;
    logic [COLORS-1:0][DOFF_W-1:0] user_digital_offset = '0;
    logic [COLORS-1:0][EO_W-1:0] manual_even_odd_offset = '0;
    int n_errors = 0, n_compared = 0, cycles = 0, n;
    // gain settings follow the recommended ranges apart from the boundary cases
    case_t cases[6] = '{'{0, 100, 8, 0, 0, 0, 0, 0, 0}, '{1, 100, 63, 1, 0, 2, -5, 0, 0},
        '{2, 10, 32, 1, 120, -3, 7, 0, 0}, '{3, 50, 16, 0, 4, 1, -100, -3, 1},
        '{1, 4000, 63, 1, 0, 0, 0, 0, 0}, '{0, 0, 8, 0, 0, -256, -2048, 0, 0}};
    int frame_x[4] = '{300, 300, 300, 210};
    logic [8:0] frame_off[4] = '{9'h1f0, 9'h1e0, 9'h1e0, 9'h1e1};
    logic frame_crs[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    pixel_gain_offset_chain #(.FIFO_WORDS(4)) u_dut (.clk_sys, .rst, .pix_in_valid, .pix_in_ready, .pix_in_sample,
        .pix_in_color, .pix_in_odd, .pix_in_dark_row, .pix_in_dark_col, .row_start, .frame_end, .analog_gain_field,
        .gain_doubler, .digital_gain_field, .manual_calibration_select, .green_lock, .manual_analog_offset,
        .blc_target_lo, .blc_target_hi, .row_black_level_calibration, .row_black_level_calibration_target, .user_digital_offset,
        .manual_even_odd_offset, .analog_offset_now, .calib_coarse, .dout_valid, .dout_ready, .dout);
    pixel_sink_model u_sink (.clk_sys, .rst, .stall, .dout_valid, .dout_ready, .dout);
    // reference arithmetic, clamping after each conversion
    function automatic logic [31:0] exp_pix(case_t k);
        int a;
        int y;
        a = ((k.x * k.g * (1 + k.m)) >>> 3) + 4 * k.ao;
        a = (a < 0) ? 0 : (a > 4095) ? 4095 : a;
        y = ((a * (8 + k.dg)) >>> 3) + k.doff + (k.odd ? k.eo : 0);
        y = (y < 0) ? 0 : (y > 4095) ? 4095 : y;
        return 32'(y);
    endfunction : exp_pix
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // valid stays up at exit so back-to-back calls never lower and raise it together
    task automatic send(input int x, input int c, input logic odd, input logic drow, input logic dcol);
        @(negedge clk_sys);
        pix_in_sample = 12'(x);
        pix_in_color = 2'(c);
        pix_in_odd = odd;
        pix_in_dark_row = drow;
        pix_in_dark_col = dcol;
        pix_in_valid = 1;
        while (!pix_in_ready) @(negedge clk_sys);
        @(posedge clk_sys);
    endtask : send
    task automatic idle();
        @(negedge clk_sys);
        pix_in_valid = 0;
        repeat (4) @(negedge clk_sys);
    endtask : idle
    task automatic wait_words(input int count);
        for (int k = 0; k < 60 && u_sink.words.size() < count; k++) @(negedge clk_sys);
    endtask : wait_words
    // the timeout ceiling sits well above the expected few hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 0;
        check(pix_in_ready, 1);
        check(dout_valid, 0);
        check(calib_coarse, 4'hf);
        foreach (cases[i]) begin
            @(negedge clk_sys);
            analog_gain_field[cases[i].c] = 6'(cases[i].g);
            gain_doubler[cases[i].c] = 1'(cases[i].m);
            digital_gain_field[cases[i].c] = 7'(cases[i].dg);
            manual_analog_offset[cases[i].c] = 9'(cases[i].ao);
            user_digital_offset[cases[i].c] = 12'(cases[i].doff);
            manual_even_odd_offset[cases[i].c] = 8'(cases[i].eo);
            send(cases[i].x, cases[i].c, 1'(cases[i].odd), 0, 0);
            idle();
            wait_words(1);
            w = u_sink.words.size() ? u_sink.words.pop_front() : 'x;
            check(w, exp_pix(cases[i]));
        end
        // fill the buffer against a stalled receiver, then drain it
        analog_gain_field[0] = 6'h08;
        manual_analog_offset[0] = '0;
        user_digital_offset[0] = '0;
        stall = 1;
        n = 0;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            pix_in_sample = 12'(n);
            pix_in_color = 0;
            pix_in_valid = 1;
            if (pix_in_ready) n++;
        end
        check(pix_in_ready, 0);
        idle();
        stall = 0;
        wait_words(n);
        for (int i = 0; i < n; i++) check(u_sink.words[i], 32'(i));
        check(dout_valid, 0);
        u_sink.words.delete();
        // automatic calibration on red: coarse steps, then a fine one
        analog_gain_field[1] = 6'h08;
        gain_doubler[1] = 0;
        manual_calibration_select = 0;
        for (int f = 0; f < 4; f++) begin
            repeat (16) send(frame_x[f], 1, 0, 1, 0);
            idle();
            frame_end = 1;
            @(negedge clk_sys);
            frame_end = 0;
            repeat (2) @(negedge clk_sys);
            check(analog_offset_now[1], frame_off[f]);
            check(calib_coarse[1], frame_crs[f]);
        end
        manual_analog_offset[1] = 9'h005;
        manual_calibration_select = 1;
        @(negedge clk_sys);
        check(analog_offset_now[1], 9'h005);
        repeat (16) send(300, 1, 0, 1, 0);
        idle();
        frame_end = 1;
        @(negedge clk_sys);
        frame_end = 0;
        manual_analog_offset[1] = 9'h1e1;
        manual_calibration_select = 0;
        repeat (2) @(negedge clk_sys);
        check(analog_offset_now[1], 9'h1e1);
        analog_gain_field[1] = 6'h09;
        repeat (2) @(negedge clk_sys);
        check(calib_coarse[1], 1);
        // green lock follows equal gain settings only
        manual_calibration_select = 1;
        manual_analog_offset[0] = 9'h00a;
        manual_analog_offset[3] = 9'h014;
        analog_gain_field[3] = 6'h08;
        gain_doubler[3] = 0;
        green_lock = 1;
        @(negedge clk_sys);
        check(analog_offset_now[3], 9'h00a);
        analog_gain_field[3] = 6'h11;
        @(negedge clk_sys);
        check(analog_offset_now[3], 9'h014);
        // row offset from eight dark columns: 50 - 20 added to 100
        analog_gain_field[1] = 6'h08;
        manual_analog_offset[1] = '0;
        row_black_level_calibration = 1;
        u_sink.words.delete();
        row_start = 1;
        @(negedge clk_sys);
        row_start = 0;
        repeat (8) send(20, 1, 0, 0, 1);
        send(100, 1, 0, 0, 0);
        idle();
        wait_words(9);
        check(u_sink.words[8], 32'd130);
        report_and_stop();
    end
endmodule : pixel_gain_offset_chain_tb
